// [verif/idc_core_checker.sv]
// Port assertions for the decode block
`timescale 1ns/100ps
module idc_core_checker
(
    input wire logic        REF_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic [11:0] INSN_WORD_I,
    input wire logic [7:0]  FLAGS_I,
    input wire logic        PRESCALE_TO_WDT_I,
    input wire logic [10:0] INSN_PTR_O,
    input wire logic        REG_WE_O,
    input wire logic [7:0]  REG_WDATA_O,
    input wire logic [7:0]  ACC_O,
    input wire logic        NULL_SET_O,
    input wire logic        PUSH_O,
    input wire logic [10:0] PUSH_DATA_O,
    input wire logic        WDT_CLEAR_O,
    input wire logic        PRESCALE_CLEAR_O,
    input wire logic        FLAGS_SET_O,
    input wire logic        CYCLE_END_O
);
    logic [10:0] tgt;
    assign tgt = {FLAGS_I[6:5], 1'b0, INSN_WORD_I[7:0]};
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    property p_cyc;
        CYCLE_END_O |=> !CYCLE_END_O[*3] ##1 CYCLE_END_O;
    endproperty
    a_cyc: assert property (p_cyc) else $error("cycle spacing");
    property p_tgt; PUSH_O |-> INSN_PTR_O == $past(tgt); endproperty
    a_tgt: assert property (p_tgt) else $error("call target");
    property p_ret;
        PUSH_O |-> PUSH_DATA_O == $past(INSN_PTR_O) + 11'h001;
    endproperty
    a_ret: assert property (p_ret) else $error("return address");
    property p_fl; PUSH_O |-> (!NULL_SET_O && !FLAGS_SET_O && !REG_WE_O)[*5];
    endproperty
    a_fl: assert property (p_fl) else $error("call flush");
    property p_zr;
        REG_WE_O |-> REG_WDATA_O == 8'h00 && NULL_SET_O;
    endproperty
    a_zr: assert property (p_zr) else $error("zero register");
    property p_za; NULL_SET_O && !REG_WE_O |-> ACC_O == 8'h00; endproperty
    a_za: assert property (p_za) else $error("zero accumulator");
    property p_wd; WDT_CLEAR_O |-> FLAGS_SET_O; endproperty
    a_wd: assert property (p_wd) else $error("watchdog service");
    property p_ps; PRESCALE_CLEAR_O |-> WDT_CLEAR_O && $past(PRESCALE_TO_WDT_I);
    endproperty
    a_ps: assert property (p_ps) else $error("prescaler clear");
    property p_end; NULL_SET_O || PUSH_O |-> $past(CYCLE_END_O); endproperty
    a_end: assert property (p_end) else $error("result off cycle end");
    c_call: cover property (PUSH_O);
    c_zreg: cover property (REG_WE_O);
    c_pres: cover property (PRESCALE_CLEAR_O);
endmodule : idc_core_checker

// [verif/idc_far_model.sv]
// Register file and flag model beside the decode block
`timescale 1ns/100ps
module idc_far_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       we_i,
    input  wire logic [4:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       null_set_i,
    input  wire logic       flags_set_i,
    input  wire logic [1:0] page_i,
    output logic      [7:0] flags_o
);
    logic [7:0] regs [32];
    logic [2:0] stat_r;
    // Page bits come from the bench so calls can target any page
    assign flags_o = {1'b0, page_i, stat_r, 2'b00};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_r <= 3'h0;
            for (int i = 0; i < 32; i++) regs[i] <= 8'h5A;
        end
        else
        begin
            if (we_i) regs[addr_i] <= wdata_i;
            if (null_set_i) stat_r[0] <= 1'b1;
            if (flags_set_i) stat_r[2:1] <= 2'h3;
        end
    end
endmodule : idc_far_model

// [verif/tb_idc_core.sv]
// Self-checking bench for the decode block
`timescale 1ns/100ps
module tb_idc_core;
    logic        clk = 1'b0, rst = 1'b1, presc = 1'b0;
    logic [11:0] word = 12'h000;
    logic [1:0]  page = 2'h0;
    logic [7:0]  flags, rwdata, acc, imm8;
    logic [10:0] ptr, pdata;
    logic [4:0]  raddr;
    logic [11:0] opc;
    logic [8:0]  imm9;
    logic [2:0]  bpos;
    logic        fetch, rwe, nset, push, wclr, pclr, fset, cend, dest;
    int          n_errors = 0;
    int          tests_run = 0;
    idc_core u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .INSN_WORD_I(word),
        .FLAGS_I(flags), .REG_RDATA_I(8'h00), .PRESCALE_TO_WDT_I(presc),
        .INSN_PTR_O(ptr), .FETCH_O(fetch), .REG_ADDR_O(raddr),
        .REG_WDATA_O(rwdata), .REG_WE_O(rwe), .ACC_O(acc), .NULL_SET_O(nset),
        .PUSH_O(push), .PUSH_DATA_O(pdata), .WDT_CLEAR_O(wclr),
        .PRESCALE_CLEAR_O(pclr), .FLAGS_SET_O(fset), .CYCLE_END_O(cend),
        .OPCODE_O(opc), .DEST_REG_O(dest), .BIT_POS_O(bpos), .IMM8_O(imm8),
        .IMM9_O(imm9));
    idc_far_model u_mod (.clk_i(clk), .rst_i(rst), .we_i(rwe), .addr_i(raddr),
        .wdata_i(rwdata), .null_set_i(nset), .flags_set_i(fset),
        .page_i(page), .flags_o(flags));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s exp %h seen %h", what, exp, got);
        end
    endtask : chk
    // Word held from one cycle end to the next; checked after it lands
    task automatic exec(input logic [11:0] w);
        int n;
        @(posedge clk);
        word <= w;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (cend !== 1'b1 && n < 8);
        @(posedge clk);
        @(negedge clk);
    endtask : exec
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic t_call;
        @(posedge clk);
        page <= 2'h2;
        exec(12'h9AB);
        chk(push, 1'b1, "push");
        chk(fetch, 1'b1, "fetch");
        chk(pdata, 11'h000, "return");
        chk(ptr, 11'h4AB, "pointer");
        chk(nset | fset, 1'b0, "flags");
        exec(12'h07F);
        chk(rwe, 1'b0, "flush write");
        chk(opc, idc_pkg::W_NOP, "flush op");
    endtask : t_call
    task automatic t_zero;
        logic [4:0] r;
        for (int i = 0; i < 2; i++)
        begin
            r = i ? 5'h1F : 5'h00;
            exec({idc_pkg::OP_ZREG, r});
            chk(rwe & nset & dest, 1'b1, "zero reg");
            chk({raddr, rwdata}, {r, 8'h00}, "zero reg data");
        end
        // Model stores on the edge after the write pulse
        @(negedge clk);
        chk(u_mod.regs[31], 8'h00, "slot 31");
        exec(idc_pkg::W_ZACC);
        chk({nset, rwe, dest, acc}, 11'h400, "zero acc");
    endtask : t_zero
    task automatic t_wdog;
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk);
            presc <= p[0];
            exec(idc_pkg::W_WDSVC);
            chk({wclr, fset, pclr}, {2'h3, p[0]}, "watchdog");
        end
    endtask : t_wdog
    task automatic t_fields;
        exec(12'hA5C);
        chk(imm9, 9'h05C, "imm9");
        chk(imm8, 8'h5C, "imm8");
        chk(bpos, 3'h2, "bit pos");
        chk({dest, push}, 2'h0, "target");
    endtask : t_fields
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(ptr, idc_pkg::PTR_RST, "reset pointer");
        chk(acc, idc_pkg::ACC_RST, "reset acc");
        t_call();
        t_zero();
        t_wdog();
        t_fields();
        test_done();
    end
    initial
    begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : tb_idc_core
bind idc_core idc_core_checker u_chk (.REF_CLK_I(REF_CLK_I),
    .SYS_RST_I(SYS_RST_I), .INSN_WORD_I(INSN_WORD_I), .FLAGS_I(FLAGS_I),
    .PRESCALE_TO_WDT_I(PRESCALE_TO_WDT_I), .INSN_PTR_O(INSN_PTR_O),
    .REG_WE_O(REG_WE_O), .REG_WDATA_O(REG_WDATA_O), .ACC_O(ACC_O),
    .NULL_SET_O(NULL_SET_O), .PUSH_O(PUSH_O), .PUSH_DATA_O(PUSH_DATA_O),
    .WDT_CLEAR_O(WDT_CLEAR_O), .PRESCALE_CLEAR_O(PRESCALE_CLEAR_O),
    .FLAGS_SET_O(FLAGS_SET_O), .CYCLE_END_O(CYCLE_END_O));

// [verilog/idc_core.sv]
// Instruction decode and execute for call, clears and watchdog service
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module idc_core
(
    input  wire logic        REF_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic [11:0] INSN_WORD_I,
    input  wire logic [7:0]  FLAGS_I,
    input  wire logic [7:0]  REG_RDATA_I,
    input  wire logic        PRESCALE_TO_WDT_I,
    output logic      [10:0] INSN_PTR_O,
    output logic             FETCH_O,
    output logic      [4:0]  REG_ADDR_O,
    output logic      [7:0]  REG_WDATA_O,
    output logic             REG_WE_O,
    output logic      [7:0]  ACC_O,
    output logic             NULL_SET_O,
    output logic             PUSH_O,
    output logic      [10:0] PUSH_DATA_O,
    output logic             WDT_CLEAR_O,
    output logic             PRESCALE_CLEAR_O,
    output logic             FLAGS_SET_O,
    output logic             CYCLE_END_O,
    output logic      [11:0] OPCODE_O,
    output logic             DEST_REG_O,
    output logic      [2:0]  BIT_POS_O,
    output logic      [7:0]  IMM8_O,
    output logic      [8:0]  IMM9_O
);
    logic [1:0]               phase_r;
    logic                     cyc_end;
    idc_pkg::idc_state_t      state_r;
    logic [10:0]              ptr_r;
    logic [7:0]               acc_r;
    logic [11:0]              insn;
    logic                     is_call;
    logic                     is_zreg;
    logic                     is_zacc;
    logic                     is_wdsvc;
    logic [10:0]              call_tgt;
    logic                     fetch_r;
    logic [4:0]               reg_addr_r;
    logic [7:0]               reg_wdata_r;
    logic                     reg_we_r;
    logic                     null_r;
    logic                     push_r;
    logic [10:0]              push_data_r;
    logic                     wdt_clr_r;
    logic                     pre_clr_r;
    logic                     flags_set_r;
    logic [11:0]              opc_r;
    logic                     dest_r;
    logic [2:0]               pos_r;
    logic [7:0]               imm8_r;
    logic [8:0]               imm9_r;

    // Field slice for the register file write address
    function automatic logic [4:0] slot_of(input logic [11:0] w);
        slot_of = w[idc_pkg::SLOT_W-1:0];
    endfunction : slot_of

    // Oscillator periods divided into an instruction cycle enable
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
            phase_r <= 2'h0;
        else
            phase_r <= phase_r + 2'h1;
    end
    assign cyc_end = (phase_r == idc_pkg::PHASE_LAST);

    // Flush cycle runs the prefetched word as a no-op
    assign insn = (state_r == idc_pkg::IDC_FLUSH) ? idc_pkg::W_NOP
                                                  : INSN_WORD_I;

    // Only zero accumulator and watchdog service are full-width compares; call ignores bits 7:0 and zero register bits 4:0
    assign is_call  = insn[11:idc_pkg::LIT_OP_LSB] == idc_pkg::OP_SUBJUMP;
    assign is_zreg  = insn[11:idc_pkg::SLOT_W] == idc_pkg::OP_ZREG;
    assign is_zacc  = insn == idc_pkg::W_ZACC;
    assign is_wdsvc = insn == idc_pkg::W_WDSVC;

    assign call_tgt = {FLAGS_I[6:idc_pkg::FLAG_PAGE_LSB], 1'b0,
                       insn[idc_pkg::DATA_W-1:0]};

    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
            state_r <= idc_pkg::IDC_EXEC;
        else if (cyc_end)
        begin
            case (state_r)
                idc_pkg::IDC_EXEC:
                    if (is_call)
                        state_r <= idc_pkg::IDC_FLUSH;
                idc_pkg::IDC_FLUSH:
                    state_r <= idc_pkg::IDC_EXEC;
                default:
                    state_r <= idc_pkg::IDC_EXEC;
            endcase
        end
    end

    // Pointer; the call loads its target on the same edge that pushes the old value plus one
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
            ptr_r <= idc_pkg::PTR_RST;
        else if (cyc_end)
            ptr_r <= is_call ? call_tgt : ptr_r + 11'h1;
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            push_r      <= 1'b0;
            push_data_r <= 11'h000;
        end
        else
        begin
            push_r      <= cyc_end && is_call;
            push_data_r <= ptr_r + 11'h1;
        end
    end

    // Accumulator: cleared by its op only; the zero register branch needs target 0, which that op never has
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
            acc_r <= idc_pkg::ACC_RST;
        else if (cyc_end && is_zacc)
            acc_r <= 8'h00;
        else if (cyc_end && is_zreg && !insn[idc_pkg::DEST_BIT])
            acc_r <= 8'h00;
    end

    // Register file write; zero register op always has target bit 1
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            reg_we_r    <= 1'b0;
            reg_addr_r  <= 5'h00;
            reg_wdata_r <= 8'h00;
        end
        else
        begin
            reg_we_r    <= cyc_end && is_zreg
                           && insn[idc_pkg::DEST_BIT];
            reg_addr_r  <= slot_of(insn);
            reg_wdata_r <= 8'h00;
        end
    end

    // Status side effects, one-cycle pulses at cycle end
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            null_r      <= 1'b0;
            wdt_clr_r   <= 1'b0;
            pre_clr_r   <= 1'b0;
            flags_set_r <= 1'b0;
            fetch_r     <= 1'b0;
        end
        else
        begin
            null_r      <= cyc_end && (is_zreg || is_zacc);
            wdt_clr_r   <= cyc_end && is_wdsvc;
            pre_clr_r   <= cyc_end && is_wdsvc
                           && PRESCALE_TO_WDT_I;
            flags_set_r <= cyc_end && is_wdsvc;
            fetch_r     <= cyc_end;
        end
    end

    // Field decode register for the rest of the datapath
    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            opc_r  <= 12'h000;
            dest_r <= 1'b1;
            pos_r  <= 3'h0;
            imm8_r <= 8'h00;
            imm9_r <= 9'h000;
        end
        else if (cyc_end)
        begin
            opc_r  <= insn;
            dest_r <= insn[idc_pkg::DEST_BIT];
            pos_r  <= insn[7:idc_pkg::POS_LSB];
            imm8_r <= insn[idc_pkg::DATA_W-1:0];
            imm9_r <= insn[idc_pkg::JMP_OP_LSB-1:0];
        end
    end

    assign INSN_PTR_O       = ptr_r;
    assign FETCH_O          = fetch_r;
    assign REG_ADDR_O       = reg_addr_r;
    assign REG_WDATA_O      = reg_wdata_r;
    assign REG_WE_O         = reg_we_r;
    assign ACC_O            = acc_r;
    assign NULL_SET_O       = null_r;
    assign PUSH_O           = push_r;
    assign PUSH_DATA_O      = push_data_r;
    assign WDT_CLEAR_O      = wdt_clr_r;
    assign PRESCALE_CLEAR_O = pre_clr_r;
    assign FLAGS_SET_O      = flags_set_r;
    assign CYCLE_END_O      = cyc_end;
    assign OPCODE_O         = opc_r;
    assign DEST_REG_O       = dest_r;
    assign BIT_POS_O        = pos_r;
    assign IMM8_O           = imm8_r;
    assign IMM9_O           = imm9_r;
endmodule : idc_core

// [verilog/idc_pkg.sv]
// Constants and types for the instruction decode and execute block
package idc_pkg;
    localparam int          OSC_PER_CYCLE  = 4;
    localparam int          OSC_MHZ        = 4;
    localparam int          CYCLE_NS       = 1000 * OSC_PER_CYCLE / OSC_MHZ;
    localparam int          PTR_W          = 11;
    localparam int          WORD_W         = 12;
    localparam int          DATA_W         = 8;
    localparam int          SLOT_W         = 5;
    localparam int          WDT_W          = 8;
    localparam int          PRE_W          = 8;
    localparam int          BYTE_OP_LSB    = 6;
    localparam int          BIT_OP_LSB     = 8;
    localparam int          LIT_OP_LSB     = 8;
    localparam int          JMP_OP_LSB     = 9;
    localparam int          DEST_BIT       = 5;
    localparam int          POS_LSB        = 5;
    localparam int          FLAG_PAGE_LSB  = 5;
    localparam logic [3:0]  OP_SUBJUMP     = 4'h9;
    localparam logic [2:0]  OP_ABSJUMP     = 3'h5;
    localparam logic [6:0]  OP_ZREG        = 7'h03;
    localparam logic [11:0] W_ZACC         = 12'h040;
    localparam logic [11:0] W_WDSVC        = 12'h004;
    localparam logic [11:0] W_NOP          = 12'h000;
    localparam logic [PTR_W-1:0] PTR_RST   = 11'h7FF;
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic [WDT_W-1:0] WDT_RST   = 8'h00;
    localparam logic [1:0]  PHASE_LAST     = 2'h3;
    typedef enum logic [1:0] {IDC_EXEC, IDC_FLUSH} idc_state_t;
endpackage : idc_pkg
